// ### pkg/ccm_pkg.sv
// package for the capture/compare unit: register map, fields, resets, enums
`default_nettype none
package ccm_pkg;
  // register word addresses (byte address = 4 * index)
  localparam logic [3:0] CCM_IDX_CTRL = 4'h0;
  localparam logic [3:0] CCM_IDX_TB_LO = 4'h1;
  localparam logic [3:0] CCM_IDX_TB_HI = 4'h2;
  localparam logic [3:0] CCM_IDX_TB_CTRL = 4'h3;
  localparam logic [3:0] CCM_IDX_RES_LO = 4'h4;
  localparam logic [3:0] CCM_IDX_RES_HI = 4'h5;
  localparam logic [3:0] CCM_IDX_FLAGS = 4'h6;
  localparam logic [3:0] CCM_IDX_ENABLES = 4'h7;
  localparam logic [3:0] CCM_IDX_STATUS = 4'h8;
  // field positions
  localparam int CCM_TBC_ON = 0;
  localparam int CCM_TBC_SRC = 1;
  localparam int CCM_TBC_SEL = 3;
  localparam int CCM_TBC_OSC = 6;
  localparam int CCM_FLG_UNIT = 0;
  localparam int CCM_FLG_TBOV = 1;
  // reset values
  localparam logic [7:0] CCM_CTRL_RST = 8'h00;
  localparam logic [7:0] CCM_TBC_RST = 8'h00;
  localparam logic [15:0] CCM_CNT_RST = 16'h0000;
  localparam logic [3:0] CCM_PRE_RST = 4'h0;
  // mode codes of unit_mode_code
  localparam logic [3:0] CCM_M_OFF = 4'h0;
  localparam logic [3:0] CCM_M_TOGGLE = 4'h2;
  localparam logic [3:0] CCM_M_CAP_FALL = 4'h4;
  localparam logic [3:0] CCM_M_CAP_RISE = 4'h5;
  localparam logic [3:0] CCM_M_CAP_4 = 4'h6;
  localparam logic [3:0] CCM_M_CAP_16 = 4'h7;
  localparam logic [3:0] CCM_M_SET_HI = 4'h8;
  localparam logic [3:0] CCM_M_SET_LO = 4'h9;
  localparam logic [3:0] CCM_M_SWINT = 4'hA;
  localparam logic [3:0] CCM_M_SPECIAL = 4'hB;
  localparam logic [3:0] CCM_PRE_4_LAST = 4'h3;
  localparam logic [3:0] CCM_PRE_16_LAST = 4'hF;
  typedef enum {CCM_UNIT_OFF, CCM_UNIT_CAPTURE, CCM_UNIT_COMPARE, CCM_UNIT_WAVE} ccm_unit_t;
  typedef struct packed {
    logic [1:0] output_config_field;
    logic [1:0] duty_low_bits;
    logic [3:0] unit_mode_code;
  } ccm_ctrl_t;
  // output pins of the unit: A as out and active-low enable, B to D as active-low enable only, plus A/C and B/D inversion
  typedef struct packed {
    logic a_out;
    logic a_oe_n;
    logic b_oe_n;
    logic c_oe_n;
    logic d_oe_n;
    logic inv_ac;
    logic inv_bd;
  } ccm_pins_t;
endpackage : ccm_pkg
`default_nettype wire

// ### rtl/ccm_edge_sync.sv
// two-stage synchroniser with rising and falling edge pulses
`default_nettype none
module ccm_edge_sync (
  input wire logic mclk,
  input wire logic rst,
  input wire logic din,
  output logic level,
  output logic rise,
  output logic fall
);
  logic meta_q;
  logic sync_q;
  logic prev_q;
  always_ff @(posedge mclk) begin
    if (rst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end
  assign level = sync_q;
  assign rise = sync_q & ~prev_q;
  assign fall = ~sync_q & prev_q;
endmodule // ccm_edge_sync
`default_nettype wire

// ### rtl/ccm_unit.sv
// capture/compare unit with mode decode and its second 16-bit timer
// What this block does
// - second timer counts 0000h..FFFFh, wraps to zero, sets overflow flag on wrap
// - overflow request leaves only when enabled; flag latches regardless
// - oscillator enable plus external source: timer advances on oscillator rising edge
// - special-event match resets the time base, starts conversion if enabled, sets flag
// - software timer write in same cycle as special-event reset wins
// - mode zero turns unit off and resets state; 0001 and 0011 reserved
// - 0100..0111 capture on falling, rising, every 4th, every 16th rising edge
// - mode 0010 toggles the compare output on match
// - 1000 starts low then sets on match; 1001 starts high then clears; both flag
// - mode 1010 only sets the flag; pin returns to port function
// - 1100..1111 waveform mode; bit1 inverts A/C, bit0 inverts B/D
// - output configuration ignored outside waveform mode; only A serves the unit
// - waveform configuration: 10 enables A and B only (half bridge); 00, 01 and 11 all enable A to D
// - duty low bits join result low byte into a 10-bit duty value
// - each qualified capture copies the selected 16-bit count to the result
// - every capture sets the flag, cleared only by software; newer overwrites
// - capture/compare use first or second timer by select bit; 8-bit timer input is unused
// - prescaler counter clears when off, leaving capture, or on reset
// - switching between capture prescale codes keeps the prescaler counter
// - port latch write while pin is output counts as an external edge
// - select bit set picks second timer as time base, clear picks first
// - compare modes compare result pair to selected timer continuously
`default_nettype none
module ccm_unit
  import ccm_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic event_pin,
  input wire logic low_power_osc,
  input wire logic [15:0] timer_a_count,
  input wire logic [7:0] timer_w_count,
  input wire logic port_latch_write,
  input wire logic port_latch_value,
  input wire logic pin_is_output,
  input wire logic converter_enabled,
  output logic timer_a_reset,
  output logic conversion_start,
  output logic unit_irq,
  output logic timer_b_irq,
  output logic [9:0] duty_value,
  output ccm_pins_t pins
);
  ccm_ctrl_t ctrl_q;
  logic [7:0] tbc_q;
  logic [15:0] tb_q;
  logic [15:0] res_q;
  logic [1:0] flags_q;
  logic [1:0] ena_q;
  logic [3:0] pre_q;
  logic out_q;
  logic match_q;
  logic acc_q;
  logic [31:0] rdata_q;
  logic tst_q;
  logic tconv_q;
  ccm_unit_t unit;
  logic pin_rise, pin_fall, pin_lvl;
  logic osc_rise;
  logic wr, rd;
  logic [3:0] idx;
  logic tb_wr_lo, tb_wr_hi;
  logic tb_tick, tb_wrap;
  logic [15:0] base;
  logic eq, match_edge;
  logic edge_sel, cap_now, cmp_flag, special;
  logic lat_rise, lat_fall;

  function automatic ccm_unit_t decode(input logic [3:0] m);
    if (m[3:2] == 2'b11) decode = CCM_UNIT_WAVE;
    else if (m[3:2] == 2'b01) decode = CCM_UNIT_CAPTURE;
    else if (m[3] || m == CCM_M_TOGGLE) decode = CCM_UNIT_COMPARE;
    else decode = CCM_UNIT_OFF; // off and reserved codes
  endfunction

  assign unit = decode(ctrl_q.unit_mode_code);

  ccm_edge_sync u_pin (
    .mclk(mclk), .rst(rst), .din(event_pin),
    .level(pin_lvl), .rise(pin_rise), .fall(pin_fall)
  );
  ccm_edge_sync u_osc (
    .mclk(mclk), .rst(rst), .din(low_power_osc),
    .level(), .rise(osc_rise), .fall()
  );

  // bus: one wait cycle, answer on the second edge
  assign avs_waitrequest = (avs_read | avs_write) & ~acc_q;
  assign wr = avs_write & acc_q;
  assign rd = avs_read & acc_q;
  assign idx = avs_address[5:2];
  assign avs_readdata = rdata_q;
  always_ff @(posedge mclk) begin
    if (rst) acc_q <= 1'b0;
    else acc_q <= (avs_read | avs_write) & ~acc_q;
  end

  always_ff @(posedge mclk) begin
    if (rst) rdata_q <= 32'h0000_0000;
    else if ((avs_read | avs_write) & ~acc_q) begin
      case (idx)
        CCM_IDX_CTRL: rdata_q <= {24'h000000, ctrl_q};
        CCM_IDX_TB_LO: rdata_q <= {24'h000000, tb_q[7:0]};
        CCM_IDX_TB_HI: rdata_q <= {24'h000000, tb_q[15:8]};
        CCM_IDX_TB_CTRL: rdata_q <= {24'h000000, tbc_q};
        CCM_IDX_RES_LO: rdata_q <= {24'h000000, res_q[7:0]};
        CCM_IDX_RES_HI: rdata_q <= {24'h000000, res_q[15:8]};
        CCM_IDX_FLAGS: rdata_q <= {30'h0000_0000, flags_q};
        CCM_IDX_ENABLES: rdata_q <= {30'h0000_0000, ena_q};
        CCM_IDX_STATUS: rdata_q <= {30'h0000_0000, pin_lvl, out_q};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) ctrl_q <= CCM_CTRL_RST;
    else if (wr && idx == CCM_IDX_CTRL && avs_byteenable[0]) ctrl_q <= avs_writedata[7:0];
  end

  always_ff @(posedge mclk) begin
    if (rst) tbc_q <= CCM_TBC_RST;
    else if (wr && idx == CCM_IDX_TB_CTRL && avs_byteenable[0])
      tbc_q <= avs_writedata[7:0] & 8'h4F;
  end

  always_ff @(posedge mclk) begin
    if (rst) ena_q <= 2'b00;
    else if (wr && idx == CCM_IDX_ENABLES && avs_byteenable[0]) ena_q <= avs_writedata[1:0];
  end

  // time base selection
  assign base = tbc_q[CCM_TBC_SEL] ? tb_q : timer_a_count;
  assign eq = (res_q == base);
  assign match_edge = eq & ~match_q;
  always_ff @(posedge mclk) begin
    if (rst) match_q <= 1'b0;
    else match_q <= eq && unit == CCM_UNIT_COMPARE;
  end
  assign special = match_edge && unit == CCM_UNIT_COMPARE
                   && ctrl_q.unit_mode_code == CCM_M_SPECIAL;

  // second timer
  assign tb_wr_lo = wr && idx == CCM_IDX_TB_LO && avs_byteenable[0];
  assign tb_wr_hi = wr && idx == CCM_IDX_TB_HI && avs_byteenable[0];
  assign tb_tick = tbc_q[CCM_TBC_ON]
                   && (tbc_q[CCM_TBC_SRC] ? (tbc_q[CCM_TBC_OSC] && osc_rise) : 1'b1);
  assign tb_wrap = tb_tick && tb_q == 16'hFFFF;
  always_ff @(posedge mclk) begin
    if (rst) tb_q <= CCM_CNT_RST;
    else if (tb_wr_lo) tb_q[7:0] <= avs_writedata[7:0];
    else if (tb_wr_hi) tb_q[15:8] <= avs_writedata[7:0];
    else if (special && tbc_q[CCM_TBC_SEL]) tb_q <= CCM_CNT_RST;
    else if (tb_tick) tb_q <= tb_q + 16'h0001;
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      tst_q <= 1'b0;
      tconv_q <= 1'b0;
    end else begin
      tst_q <= special && !tbc_q[CCM_TBC_SEL];
      tconv_q <= special && converter_enabled;
    end
  end
  assign timer_a_reset = tst_q;
  assign conversion_start = tconv_q;

  // capture qualification and prescaler
  assign lat_rise = pin_is_output && port_latch_write && port_latch_value && !pin_lvl;
  assign lat_fall = pin_is_output && port_latch_write && !port_latch_value && pin_lvl;
  assign edge_sel = (ctrl_q.unit_mode_code == CCM_M_CAP_FALL) ? (pin_fall | lat_fall)
                                                              : (pin_rise | lat_rise);
  always_ff @(posedge mclk) begin
    if (rst || unit != CCM_UNIT_CAPTURE) pre_q <= CCM_PRE_RST;
    else if (edge_sel) pre_q <= pre_q + 4'h1; // prescale switch keeps count
  end
  always_comb begin
    cap_now = 1'b0;
    if (unit == CCM_UNIT_CAPTURE && edge_sel) begin
      case (ctrl_q.unit_mode_code)
        CCM_M_CAP_4: cap_now = (pre_q[1:0] == CCM_PRE_4_LAST[1:0]);
        CCM_M_CAP_16: cap_now = (pre_q == CCM_PRE_16_LAST);
        default: cap_now = 1'b1;
      endcase
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) res_q <= CCM_CNT_RST;
    else if (cap_now) res_q <= base; // overwrites unread result
    else if (wr && idx == CCM_IDX_RES_LO && avs_byteenable[0]) res_q[7:0] <= avs_writedata[7:0];
    else if (wr && idx == CCM_IDX_RES_HI && avs_byteenable[0]) res_q[15:8] <= avs_writedata[7:0];
  end

  // compare output latch
  always_ff @(posedge mclk) begin
    if (rst) out_q <= 1'b0;
    else if (wr && idx == CCM_IDX_CTRL && avs_byteenable[0]) begin
      if (avs_writedata[3:0] == CCM_M_SET_LO) out_q <= 1'b1;
      else if (avs_writedata[3:0] == CCM_M_SET_HI || avs_writedata[3:0] == CCM_M_OFF)
        out_q <= 1'b0;
    end else if (match_edge && unit == CCM_UNIT_COMPARE) begin
      case (ctrl_q.unit_mode_code)
        CCM_M_TOGGLE: out_q <= ~out_q;
        CCM_M_SET_HI: out_q <= 1'b1;
        CCM_M_SET_LO: out_q <= 1'b0;
        default: out_q <= out_q;
      endcase
    end
  end

  // flags: set wins over a software clear (write one to clear)
  assign cmp_flag = match_edge && unit == CCM_UNIT_COMPARE
                    && ctrl_q.unit_mode_code != CCM_M_TOGGLE;
  always_ff @(posedge mclk) begin
    if (rst) flags_q <= 2'b00;
    else begin
      if (cap_now || cmp_flag) flags_q[CCM_FLG_UNIT] <= 1'b1;
      else if (wr && idx == CCM_IDX_FLAGS && avs_writedata[CCM_FLG_UNIT])
        flags_q[CCM_FLG_UNIT] <= 1'b0;
      if (tb_wrap) flags_q[CCM_FLG_TBOV] <= 1'b1;
      else if (wr && idx == CCM_IDX_FLAGS && avs_writedata[CCM_FLG_TBOV])
        flags_q[CCM_FLG_TBOV] <= 1'b0;
    end
  end
  assign unit_irq = flags_q[CCM_FLG_UNIT] & ena_q[CCM_FLG_UNIT];
  assign timer_b_irq = flags_q[CCM_FLG_TBOV] & ena_q[CCM_FLG_TBOV];

  // pin routing and waveform decode
  assign duty_value = {res_q[7:0], ctrl_q.duty_low_bits};
  always_comb begin
    pins = '{a_out: out_q, a_oe_n: 1'b1, b_oe_n: 1'b1, c_oe_n: 1'b1, d_oe_n: 1'b1,
             inv_ac: 1'b0, inv_bd: 1'b0};
    case (unit)
      CCM_UNIT_COMPARE: pins.a_oe_n = (ctrl_q.unit_mode_code == CCM_M_SWINT);
      CCM_UNIT_WAVE: begin
        pins.inv_ac = ctrl_q.unit_mode_code[1];
        pins.inv_bd = ctrl_q.unit_mode_code[0];
        pins.a_oe_n = 1'b0;
        pins.b_oe_n = 1'b0;
        pins.c_oe_n = (ctrl_q.output_config_field == 2'b10);
        pins.d_oe_n = (ctrl_q.output_config_field == 2'b10);
      end
      default: pins.a_oe_n = 1'b1;
    endcase
  end

  // assertions
  // a software write to the count wins over the wrap, so it is left out here
  ovf_flag_a: assert property (@(posedge mclk) disable iff (rst)
    tb_wrap && !tb_wr_lo && !tb_wr_hi |=> flags_q[CCM_FLG_TBOV] && tb_q == 16'h0000)
    else $error("overflow flag missing");
  irq_gate_a: assert property (@(posedge mclk) disable iff (rst)
    flags_q[CCM_FLG_TBOV] && !(wr && idx == CCM_IDX_FLAGS)
    |=> flags_q[CCM_FLG_TBOV] && timer_b_irq == ena_q[CCM_FLG_TBOV])
    else $error("irq gate");
  special_rst_a: assert property (@(posedge mclk) disable iff (rst)
    special && tbc_q[CCM_TBC_SEL] && !tb_wr_lo && !tb_wr_hi |=> tb_q == 16'h0000)
    else $error("special reset missed");
  write_wins_a: assert property (@(posedge mclk) disable iff (rst)
    special && tb_wr_lo |=> tb_q[7:0] == $past(avs_writedata[7:0]))
    else $error("write lost");
  pre_clear_a: assert property (@(posedge mclk) disable iff (rst)
    unit != CCM_UNIT_CAPTURE |=> pre_q == 4'h0)
    else $error("prescaler not cleared");
  cap_copy_a: assert property (@(posedge mclk) disable iff (rst)
    cap_now |=> res_q == $past(base) && flags_q[CCM_FLG_UNIT])
    else $error("capture lost");
  toggle_a: assert property (@(posedge mclk) disable iff (rst)
    match_edge && ctrl_q.unit_mode_code == CCM_M_TOGGLE && !wr |=> out_q != $past(out_q))
    else $error("toggle missed");
  cap16_a: assert property (@(posedge mclk) disable iff (rst)
    cap_now && ctrl_q.unit_mode_code == CCM_M_CAP_16 |-> pre_q == 4'hF)
    else $error("prescale 16 wrong");
endmodule // ccm_unit
`default_nettype wire

// ### tb/ccm_pin_model.sv
// far-side model: external event source and low-power oscillator
`default_nettype none
module ccm_pin_model #(
  parameter int EDGE_DELAY = 13
) (
  input wire logic want_lvl,
  input wire logic osc_run,
  output logic event_pin,
  output logic low_power_osc
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    event_pin = 1'b0;
    low_power_osc = 1'b0;
  end
  // pin follows the request late, out of phase with the system clock
  always @(want_lvl) begin
    event_pin <= #(EDGE_DELAY) want_lvl;
  end
  // oscillator stands low unless asked to run; a started period completes
  always begin
    wait (osc_run);
    #23 low_power_osc = 1'b1;
    #23 low_power_osc = 1'b0;
  end
endmodule // ccm_pin_model
`default_nettype wire

// ### tb/tb_top.sv
// self-checking bench for the capture/compare unit
`default_nettype none
module tb_top
  import ccm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [3:0] i; logic [7:0] d; logic [7:0] e;} ccm_row_t;
  logic mclk, rst, avs_read, avs_write, avs_waitrequest, want_lvl, osc_run;
  logic event_pin, low_power_osc, pl_write, pl_value, pin_out, conv_en;
  logic timer_a_reset, conversion_start, unit_irq, timer_b_irq, seen_rst, seen_conv;
  logic [5:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [15:0] ta;
  logic [9:0] duty_value;
  logic [3:0] cm [4] = '{4'h8, 4'h9, 4'h2, 4'hA};
  logic [2:0] ini = 3'b010;
  logic [2:0] fin = 3'b101;
  ccm_pins_t pins;
  int n_errors = 0;
  int n_compared = 0;
  int n_osc = 0;
  int n_last;
  ccm_row_t rows [9] = '{'{CCM_IDX_CTRL, 8'hC5, 8'hC5}, '{CCM_IDX_CTRL, 8'h00, 8'h00},
    '{CCM_IDX_TB_CTRL, 8'hFF, 8'h4F}, '{CCM_IDX_TB_CTRL, 8'h00, 8'h00},
    '{CCM_IDX_TB_LO, 8'h34, 8'h34}, '{CCM_IDX_TB_HI, 8'h12, 8'h12},
    '{CCM_IDX_RES_LO, 8'h3C, 8'h3C}, '{CCM_IDX_RES_HI, 8'hA5, 8'hA5}, '{4'h9, 8'h77, 8'h00}};
  ccm_unit dut (.mclk(mclk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .event_pin(event_pin),
    .low_power_osc(low_power_osc), .timer_a_count(ta), .timer_w_count(ta[7:0]),
    .port_latch_write(pl_write), .port_latch_value(pl_value), .pin_is_output(pin_out),
    .converter_enabled(conv_en), .timer_a_reset(timer_a_reset),
    .conversion_start(conversion_start), .unit_irq(unit_irq), .timer_b_irq(timer_b_irq),
    .duty_value(duty_value), .pins(pins));
  ccm_pin_model #(.EDGE_DELAY(13)) far (.want_lvl(want_lvl), .osc_run(osc_run),
    .event_pin(event_pin), .low_power_osc(low_power_osc));
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (timer_a_reset === 1'b1) seen_rst <= 1'b1;
    if (conversion_start === 1'b1) seen_conv <= 1'b1;
  end
  always @(posedge low_power_osc) n_osc++;
  task automatic stop_test();
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask
  // hold the request until waitrequest is seen low at a rising edge
  task automatic xfer(input logic w, input logic [3:0] i, input logic [7:0] d);
    logic busy;
    busy = 1'b1;
    avs_address <= {i, 2'b00};
    avs_writedata <= {24'h0, d};
    avs_write <= w;
    avs_read <= ~w;
    while (busy) begin
      @(posedge mclk);
      busy = (avs_waitrequest !== 1'b0);
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wr(input logic [3:0] i, input logic [7:0] d);
    xfer(1'b1, i, d);
  endtask
  task automatic rd(input logic [3:0] i, input logic [7:0] e, input string nm);
    xfer(1'b0, i, 8'h00);
    chk(nm, {24'h0, e}, q);
  endtask
  task automatic clr();
    wr(CCM_IDX_FLAGS, 8'h03);
  endtask
  task automatic pin(input logic v);
    want_lvl <= v;
    repeat (8) @(posedge mclk);
  endtask
  task automatic cyc();
    pin(1'b1);
    pin(1'b0);
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  initial begin
    repeat (40000) @(posedge mclk);
    n_errors++;
    stop_test();
  end
  initial begin
    rst = 1'b1;
    {avs_read, avs_write, want_lvl, osc_run, pl_write, pl_value, pin_out, conv_en} = '0;
    {seen_rst, seen_conv} = '0;
    avs_address = '0;
    avs_writedata = '0;
    ta = 16'h0000;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    chk("pins after reset", {25'h0, pins}, {25'h0, 7'b0111100});
    for (int i = 0; i < 9; i++) begin
      rd(4'(i), 8'h00, "reset value");
    end
    foreach (rows[k]) begin
      wr(rows[k].i, rows[k].d);
      rd(rows[k].i, rows[k].e, "register readback");
    end
    done("registers");
    for (int k = 0; k < 4; k++) begin
      ta <= 16'h00A0 + 16'(k);
      wr(CCM_IDX_CTRL, 8'h00);
      wr(CCM_IDX_CTRL, 8'h04 + 8'(k));
      clr();
      n_last = (k == 2) ? 4 : (k == 3) ? 16 : 1;
      for (int j = 1; j <= n_last; j++) begin
        pin(1'b1);
        rd(CCM_IDX_FLAGS, {7'h0, k != 0 && j == n_last}, "rise flag");
        pin(1'b0);
        rd(CCM_IDX_FLAGS, {7'h0, j == n_last}, "fall flag");
      end
      rd(CCM_IDX_RES_LO, 8'hA0 + 8'(k), "captured low");
    end
    wr(CCM_IDX_CTRL, 8'h05);
    ta <= 16'hBEEF;
    cyc();
    ta <= 16'h1234;
    cyc();
    rd(CCM_IDX_RES_HI, 8'h12, "newer capture");
    chk("irq masked", 32'h0, {31'h0, unit_irq});
    wr(CCM_IDX_ENABLES, 8'h01);
    chk("irq enabled", 32'h1, {31'h0, unit_irq});
    clr();
    chk("irq cleared", 32'h0, {31'h0, unit_irq});
    wr(CCM_IDX_ENABLES, 8'h00);
    done("capture");
    wr(CCM_IDX_CTRL, 8'h00);
    wr(CCM_IDX_CTRL, 8'h07);
    repeat (3) cyc();
    wr(CCM_IDX_CTRL, 8'h06);
    clr();
    cyc();
    rd(CCM_IDX_FLAGS, 8'h01, "prescale kept");
    repeat (3) cyc();
    wr(CCM_IDX_CTRL, 8'h00);
    wr(CCM_IDX_CTRL, 8'h06);
    clr();
    repeat (3) cyc();
    rd(CCM_IDX_FLAGS, 8'h00, "prescale cleared");
    done("prescaler");
    wr(CCM_IDX_TB_LO, 8'h21);
    wr(CCM_IDX_TB_HI, 8'h43);
    wr(CCM_IDX_TB_CTRL, 8'h08);
    wr(CCM_IDX_CTRL, 8'h05);
    cyc();
    rd(CCM_IDX_RES_HI, 8'h43, "second timer base");
    rd(CCM_IDX_RES_LO, 8'h21, "second timer base");
    wr(CCM_IDX_TB_LO, 8'hFD);
    wr(CCM_IDX_TB_HI, 8'hFF);
    clr();
    wr(CCM_IDX_TB_CTRL, 8'h01);
    repeat (6) @(posedge mclk);
    rd(CCM_IDX_FLAGS, 8'h02, "overflow flag");
    chk("overflow masked", 32'h0, {31'h0, timer_b_irq});
    wr(CCM_IDX_ENABLES, 8'h02);
    chk("overflow irq", 32'h1, {31'h0, timer_b_irq});
    wr(CCM_IDX_TB_CTRL, 8'h00);
    rd(CCM_IDX_TB_HI, 8'h00, "wrapped count");
    wr(CCM_IDX_ENABLES, 8'h00);
    clr();
    wr(CCM_IDX_TB_LO, 8'h00);
    wr(CCM_IDX_TB_CTRL, 8'h43);
    n_osc = 0;
    osc_run <= 1'b1;
    repeat (40) @(posedge mclk);
    osc_run <= 1'b0;
    repeat (12) @(posedge mclk);
    wr(CCM_IDX_TB_CTRL, 8'h00);
    rd(CCM_IDX_TB_LO, 8'(n_osc), "oscillator count");
    done("timer");
    wr(CCM_IDX_RES_LO, 8'h00);
    wr(CCM_IDX_RES_HI, 8'h01);
    for (int k = 0; k < 4; k++) begin
      wr(CCM_IDX_CTRL, 8'h00);
      wr(CCM_IDX_CTRL, {4'h0, cm[k]});
      clr();
      if (k < 3) chk("initial level", {31'h0, ini[k]}, {31'h0, pins.a_out});
      ta <= 16'h0100;
      @(posedge mclk);
      ta <= 16'h0000;
      repeat (4) @(posedge mclk);
      if (k < 3) chk("match level", {31'h0, fin[k]}, {31'h0, pins.a_out});
      rd(CCM_IDX_FLAGS, {7'h0, cm[k] != 4'h2}, "compare flag");
    end
    conv_en <= 1'b1;
    wr(CCM_IDX_CTRL, 8'h0B);
    clr();
    seen_rst <= 1'b0;
    seen_conv <= 1'b0;
    ta <= 16'h0100;
    @(posedge mclk);
    ta <= 16'h0000;
    repeat (4) @(posedge mclk);
    chk("first timer reset", 32'h1, {31'h0, seen_rst});
    chk("conversion start", 32'h1, {31'h0, seen_conv});
    rd(CCM_IDX_FLAGS, 8'h01, "special flag");
    wr(CCM_IDX_TB_LO, 8'hFC);
    seen_rst <= 1'b0;
    wr(CCM_IDX_TB_CTRL, 8'h09);
    repeat (20) @(posedge mclk);
    wr(CCM_IDX_TB_CTRL, 8'h08);
    rd(CCM_IDX_TB_HI, 8'h00, "second timer reset");
    chk("first timer left", 32'h0, {31'h0, seen_rst});
    // the count reaches the compare value exactly as the next write lands
    wr(CCM_IDX_TB_LO, 8'hFE);
    wr(CCM_IDX_TB_CTRL, 8'h09);
    wr(CCM_IDX_TB_LO, 8'h40);
    wr(CCM_IDX_TB_CTRL, 8'h00);
    rd(CCM_IDX_TB_HI, 8'h01, "write beats reset");
    conv_en <= 1'b0;
    done("compare");
    wr(CCM_IDX_RES_LO, 8'hAB);
    wr(CCM_IDX_CTRL, 8'h2E);
    chk("duty value", {22'h0, 10'h2AE}, {22'h0, duty_value});
    chk("invert ac", 32'h2, {30'h0, pins.inv_ac, pins.inv_bd});
    wr(CCM_IDX_CTRL, 8'h1D);
    chk("invert bd", 32'h1, {30'h0, pins.inv_ac, pins.inv_bd});
    wr(CCM_IDX_CTRL, 8'hC8);
    chk("port pins", 32'h7, {29'h0, pins.b_oe_n, pins.c_oe_n, pins.d_oe_n});
    wr(CCM_IDX_CTRL, 8'h8C);
    chk("half bridge", 32'h3, {29'h0, pins.b_oe_n, pins.c_oe_n, pins.d_oe_n});
    wr(CCM_IDX_CTRL, 8'h4C);
    chk("full bridge", 32'h0, {28'h0, pins[5:2]});
    done("waveform");
    wr(CCM_IDX_CTRL, 8'h05);
    clr();
    ta <= 16'h5555;
    pin_out <= 1'b1;
    pl_value <= 1'b1;
    @(posedge mclk);
    pl_write <= 1'b1;
    @(posedge mclk);
    pl_write <= 1'b0;
    repeat (8) @(posedge mclk);
    rd(CCM_IDX_RES_LO, 8'h55, "latch write capture");
    done("port latch");
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
